// *** src/ieflg_defs.vh ***
`ifndef IEFLG_DEFS_VH
`define IEFLG_DEFS_VH

// ==========================================================================
// Register byte addresses
`define IEFLG_ADDR_VCW_LO 8'h00
`define IEFLG_ADDR_VCW_HI 8'h04
`define IEFLG_ADDR_IRQ_STATUS 8'h08
`define IEFLG_ADDR_IRQ_MASK 8'h0C
`define IEFLG_ADDR_W 8

// ==========================================================================
// Field layout of the interface error field
`define IEFLG_FIELD_W 8
`define IEFLG_BIT_RESP_ERROR_RECEIVED 0
`define IEFLG_BIT_RESP_ERROR_SENT 1
`define IEFLG_BIT_BAD_REGISTER 2
`define IEFLG_BIT_UNEXPECTED_RESPONSE 3
`define IEFLG_STD_W 6
`define IEFLG_RESERVED_MASK 8'hC0

// ==========================================================================
// Reset values
`define IEFLG_FIELD_RESET 8'h00
`define IEFLG_MASK_RESET 8'h00
`define IEFLG_IRQ_RESET 8'h00
`define IEFLG_MERR_VALUE 8'h00

// ==========================================================================
// Defaults of the identity parameters; values are arbitrary
`define IEFLG_DEF_IMPL 6'h0F
`define IEFLG_DEF_MOD_VERS 16'h0001
`define IEFLG_DEF_MOD_ID 16'h0A5A
`define IEFLG_DEF_BOT_MB 8'h10
`define IEFLG_DEF_TOP_MB 8'h10

// ==========================================================================
// AHB encodings
`define IEFLG_HTRANS_NONSEQ_BIT 1
`define IEFLG_HRESP_OKAY 1'b0

`endif

// *** src/ieflg_regs.v ***
`timescale 1ns/1ps
`include "ieflg_defs.vh"
// Function
// - The error field is eight bits wide and its two reserved bits read zero.
// - Six flags are standard, any subset is implemented, the rest act reserved.
// - Every flag is zero after a hard reset.
// - Hardware sets an implemented flag to one on its error condition.
// - Hardware never clears a flag except at hard reset.
// - Software may read and write the flags at any time and reads see them now.
// - When one request raises several conditions, this module sets them all.
// - Bit 0 is set when an error response arrives from the packet router.
// - Bit 1 is set when this module sends an error response to the router.
// - Bit 2 is set when a request targets an undefined control register.
// - A write to an implemented flag replaces it with the written value unless its error condition sets it in the same cycle.
// - A write to an unimplemented flag leaves the state unchanged.
// - Bit 3 is set when a response matches no outstanding request.
// - The flags sit in bits 7:0 of the version control word at offset zero.

module ieflg_regs #(
  parameter [5:0] IMPL_MASK = `IEFLG_DEF_IMPL,
  parameter [15:0] MOD_VERS = `IEFLG_DEF_MOD_VERS,
  parameter [15:0] MOD_ID = `IEFLG_DEF_MOD_ID,
  parameter [7:0] BOT_MB = `IEFLG_DEF_BOT_MB,
  parameter [7:0] TOP_MB = `IEFLG_DEF_TOP_MB
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire resp_error_received,
  input wire resp_error_sent,
  input wire bad_register_request,
  input wire unexpected_response,
  input wire [1:0] std_error_extra,
  input wire router_only_responder,
  input wire router_response_valid,
  output wire [7:0] interface_error_field,
  output wire irq
);

  // ========================================================================
  // Bus address phase capture
  reg wr_pend_q;
  reg [`IEFLG_ADDR_W-1:0] wr_addr_q;
  reg unmapped_q;
  wire addr_phase;
  wire [`IEFLG_ADDR_W-1:0] a_addr;
  wire a_mapped;
  wire a_word;

  assign addr_phase = hsel & hready & htrans[`IEFLG_HTRANS_NONSEQ_BIT];
  assign a_addr = haddr[`IEFLG_ADDR_W-1:0];
  assign a_word = (hsize == 3'h2) && (haddr[1:0] == 2'h0);
  assign a_mapped = (haddr[31:`IEFLG_ADDR_W] == 24'h000000) && a_word &&
                    ((a_addr == `IEFLG_ADDR_VCW_LO) ||
                     (a_addr == `IEFLG_ADDR_VCW_HI) ||
                     (a_addr == `IEFLG_ADDR_IRQ_STATUS) ||
                     (a_addr == `IEFLG_ADDR_IRQ_MASK));

  // Zero wait states, so no access is ever stalled
  assign hreadyout = 1'b1;
  assign hresp = `IEFLG_HRESP_OKAY;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      unmapped_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_phase & hwrite & a_mapped;
      wr_addr_q <= a_addr;
      unmapped_q <= addr_phase & ~a_mapped;
    end
  end

  // ========================================================================
  // Hardware error events
  wire [5:0] evt;
  wire unsolicited;

  // A module that never issues requests sees every response as unexpected
  assign unsolicited = unexpected_response |
                       (router_only_responder & router_response_valid);

  // Conditions raised together are all recorded, none suppressed
  assign evt[`IEFLG_BIT_RESP_ERROR_RECEIVED] = resp_error_received;
  assign evt[`IEFLG_BIT_RESP_ERROR_SENT] = resp_error_sent;
  // Unmapped register bus accesses count as undefined register requests
  assign evt[`IEFLG_BIT_BAD_REGISTER] = bad_register_request |
                                        unmapped_q;
  assign evt[`IEFLG_BIT_UNEXPECTED_RESPONSE] = unsolicited;
  assign evt[5:4] = std_error_extra;

  // ========================================================================
  // Interface error field
  reg [5:0] flags_q;
  reg [5:0] flags_d;
  wire wr_vcw_lo;
  wire [5:0] evt_impl;

  assign wr_vcw_lo = wr_pend_q && (wr_addr_q == `IEFLG_ADDR_VCW_LO);
  assign evt_impl = evt & IMPL_MASK;

  always @* begin
    flags_d = flags_q;
    if (wr_vcw_lo) begin
      flags_d = (hwdata[5:0] & IMPL_MASK) |
                (flags_q & ~IMPL_MASK);
    end
    // Set applied last so a coincident write cannot drop an error
    flags_d = flags_d | evt_impl;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= 6'h00;
    end else begin
      flags_q <= flags_d & IMPL_MASK;
    end
  end

  // Two top bits are reserved and always read zero
  assign interface_error_field = {2'b00, flags_q};

  // ========================================================================
  // Interrupt status and mask
  reg [7:0] irq_stat_q;
  reg [7:0] irq_stat_d;
  reg [7:0] irq_mask_q;
  reg [7:0] irq_mask_d;
  wire wr_stat;
  wire wr_mask;
  wire [7:0] evt_byte;

  assign wr_stat = wr_pend_q && (wr_addr_q == `IEFLG_ADDR_IRQ_STATUS);
  assign wr_mask = wr_pend_q && (wr_addr_q == `IEFLG_ADDR_IRQ_MASK);
  assign evt_byte = {2'b00, evt_impl};

  always @* begin
    irq_stat_d = irq_stat_q;
    irq_mask_d = irq_mask_q;
    if (wr_stat) begin
      irq_stat_d = irq_stat_q & ~hwdata[7:0];
    end
    if (wr_mask) begin
      irq_mask_d = hwdata[7:0] & ~`IEFLG_RESERVED_MASK;
    end
    // New events outrank a write-one-to-clear in the same cycle
    irq_stat_d = irq_stat_d | evt_byte;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= `IEFLG_IRQ_RESET;
      irq_mask_q <= `IEFLG_MASK_RESET;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ========================================================================
  // Read data
  // Read path uses next-state values so a write just before a read is seen
  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h00000000;
    case (a_addr)
      `IEFLG_ADDR_VCW_LO: begin
        rd_d = {MOD_VERS, `IEFLG_MERR_VALUE, 2'b00, flags_d};
      end
      `IEFLG_ADDR_VCW_HI: begin
        rd_d = {TOP_MB, BOT_MB, MOD_ID};
      end
      `IEFLG_ADDR_IRQ_STATUS: begin
        rd_d = {24'h000000, irq_stat_d};
      end
      `IEFLG_ADDR_IRQ_MASK: begin
        rd_d = {24'h000000, irq_mask_d};
      end
      default: begin
        rd_d = 32'h00000000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase & ~hwrite) begin
      hrdata <= a_mapped ? rd_d : 32'h00000000;
    end
  end

endmodule

// *** test/ieflg_checker.sv ***
`timescale 1ns/1ps
// ==========================================
// Flag field checker
module ieflg_checker #(
  parameter [5:0] IMPL_MASK = 6'h0F
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire resp_error_received,
  input wire resp_error_sent,
  input wire bad_register_request,
  input wire unexpected_response,
  input wire router_only_responder,
  input wire router_response_valid,
  input wire [7:0] interface_error_field
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reg wr_dp_q;
  wire take = hsel && hready && htrans[1];
  // Data phase of a write to the version word; only cause of a clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wr_dp_q <= 1'b0;
    else
      wr_dp_q <= take && hwrite && haddr == 32'h0;
  end
  res_zero_a: assert property (interface_error_field[7:6] == 2'h0)
    else $error("reserved flag bits set");
  unimpl_zero_a: assert property
    ((interface_error_field[5:0] & ~IMPL_MASK) == 6'h00)
    else $error("unimplemented flag set");
  rcv_set_a: assert property
    (resp_error_received |=> interface_error_field[0])
    else $error("received error not flagged");
  snt_set_a: assert property
    (resp_error_sent |=> interface_error_field[1])
    else $error("sent error not flagged");
  bad_set_a: assert property
    (bad_register_request |=> interface_error_field[2])
    else $error("bad register not flagged");
  unsol_set_a: assert property
    (unexpected_response || router_only_responder && router_response_valid
      |=> interface_error_field[3])
    else $error("unexpected response not flagged");
  unmap_bad_a: assert property
    (take && haddr[31:8] != 24'h0 |-> ##[1:2] interface_error_field[2])
    else $error("unmapped access not flagged");
  no_self_clr_a: assert property
    (|($past(interface_error_field) & ~interface_error_field)
      |-> $past(wr_dp_q))
    else $error("flag cleared without write");
  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
endmodule
bind ieflg_regs ieflg_checker #(.IMPL_MASK(IMPL_MASK)) ieflg_checker_i (.*);

// *** test/ieflg_router_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Router stand-in: replays commands as events
module ieflg_router_model (
  input wire hclk,
  input wire [7:0] cmd,
  output logic [7:0] ev
);
  initial ev = 8'h00;
  always @(posedge hclk) ev <= cmd;
endmodule

// *** test/interface_error_flag_byte_bench.sv ***
`timescale 1ns/1ps
`include "ieflg_defs.vh"
// ==========================================
// Flag byte bench
module interface_error_flag_byte_bench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic rd_dp = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, d;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] cmd = 8'h00, e = 8'h00;
  wire [7:0] ev, fld;
  wire hreadyout, hresp, irq;
  wire [31:0] hrdata;
  logic [31:0] expq[$];
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  initial begin
    forever #5 hclk = ~hclk;
  end
  ieflg_router_model ieflg_router_model_i (.hclk(hclk), .cmd(cmd), .ev(ev));
  ieflg_regs ieflg_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .resp_error_received(ev[0]),
    .resp_error_sent(ev[1]), .bad_register_request(ev[2]),
    .unexpected_response(ev[3]), .std_error_extra(ev[5:4]),
    .router_response_valid(ev[6]), .router_only_responder(ev[7]),
    .interface_error_field(fld), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, wd, ex);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    if (!w)
      expq.push_back(ex);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    #1;
  endtask
  task automatic hit(input logic [7:0] c);
    cmd <= c;
    @(posedge hclk);
    cmd <= 8'h00;
    repeat (2) @(posedge hclk);
    #1;
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Read data is judged at the edge that ends its data phase
  always @(posedge hclk) begin
    if (rd_dp)
      chk(hrdata, expq.pop_front());
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h89B60596));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    #1 chk(32'(fld), 32'h0);
    bus(0, 32'h0, 32'h0, {`IEFLG_DEF_MOD_VERS, 16'h0000});
    bus(0, 32'h4, 32'h0, {`IEFLG_DEF_TOP_MB, `IEFLG_DEF_BOT_MB,
      `IEFLG_DEF_MOD_ID});
    for (int b = 0; b < 6; b++) begin
      hit(8'h01 << b);
      e = e | ((8'h01 << b) & 8'h0F);
      chk(32'(fld), 32'(e));
    end
    bus(1, 32'h0, 32'h0, 32'h0);
    chk(32'(fld), 32'h0);
    hit(8'hC0);
    chk(32'(fld), 32'h8);
    hit(8'h0F);
    chk(32'(fld), 32'hF);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      bus(1, 32'h0, d, 32'h0);
      bus(0, 32'h0, 32'h0, {`IEFLG_DEF_MOD_VERS, 8'h00,
        d[7:0] & 8'h0F});
    end
    bus(0, 32'h100, 32'h0, 32'h0);
    chk(32'(fld & 8'h04), 32'h4);
    bus(1, 32'h8, 32'hFF, 32'h0);
    bus(1, 32'hC, 32'h2, 32'h0);
    chk(32'(irq), 32'h0);
    hit(8'h02);
    bus(0, 32'h8, 32'h0, 32'h2);
    chk(32'(irq), 32'h1);
    bus(1, 32'hC, 32'h0, 32'h0);
    chk(32'(irq), 32'h0);
    bus(1, 32'hC, 32'h2, 32'h0);
    bus(1, 32'h8, 32'h2, 32'h0);
    chk(32'(irq), 32'h0);
    hit(8'h01);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1 chk(32'(fld), 32'h0);
    chk(32'(irq), 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 32'h0, 32'h0, {`IEFLG_DEF_MOD_VERS, 16'h0000});
    // Byte-sized access counts as an undefined register request
    hsize <= 3'h0;
    bus(0, 32'h0, 32'h0, 32'h0);
    hsize <= 3'h2;
    chk(32'(fld & 8'h04), 32'h4);
    summarize();
  end
endmodule
